// ### hdl/external_data_ram_pkg.sv
// constants for the paged external data ram block
// assumes a single 20 MHz system clock domain
`default_nettype none
package ext_ram_pkg;
  localparam int          RAM_BYTES      = 512;
  localparam int          RAM_AW         = 9;
  localparam logic [7:0]  PAGE_REG_ADDR  = 8'haa;
  localparam logic [7:0]  PAGE_REG_RESET = 8'h00;
  localparam int          PAGE_BIT_POS   = 0;
  localparam logic [6:0]  PAGE_REG_UNUSED = 7'h00;
endpackage : ext_ram_pkg
`default_nettype wire

// ### hdl/paged_ext_data_ram.sv
// paged external data ram: 512 bytes in the external data space
// assumes the core presents one access per strobe, synchronous to sys_clk
`default_nettype none

module paged_ext_data_ram
  import ext_ram_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // special function register port
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  // external move port
  input  wire logic        xmove_en,
  input  wire logic        xmove_wr,
  input  wire logic        xmove_indirect,
  input  wire logic [15:0] data_pointer,
  input  wire logic [7:0]  xmove_reg_addr,
  input  wire logic [7:0]  xmove_wdata,
  output logic      [7:0]  xmove_rdata,
  input  wire logic        flash_write_enable,
  output logic             flash_write_req
);

  logic [7:0]        ram_r [RAM_BYTES];
  logic              page_select_bit_r;
  logic [7:0]        xmove_rdata_r;
  logic              flash_write_req_r;

  wire  [7:0]        ext_ram_page_register;
  wire  [15:0]       eff_addr;
  wire  [RAM_AW-1:0] ram_idx;
  wire               ram_wr;
  wire               page_wr;
  wire               xm_read;
  wire               xm_write;
  wire               flash_write_req_nxt;

  // true for a strobed access in the wanted direction
  function automatic logic access_of(input logic strobe,
                                     input logic want_wr,
                                     input logic is_wr);
    return strobe && (is_wr == want_wr);
  endfunction : access_of

  assign ext_ram_page_register = {PAGE_REG_UNUSED, page_select_bit_r};
  assign page_wr  = sfr_wr && (sfr_addr == PAGE_REG_ADDR);
  assign eff_addr = xmove_indirect ?
                    {ext_ram_page_register, xmove_reg_addr} :
                    data_pointer;
  assign ram_idx  = eff_addr[RAM_AW-1:0];
  assign xm_read  = access_of(xmove_en, 1'b0, xmove_wr);
  assign xm_write = access_of(xmove_en, 1'b1, xmove_wr);
  assign ram_wr   = xm_write && !flash_write_enable;
  assign flash_write_req_nxt = xm_write && flash_write_enable;
  assign sfr_rdata = (sfr_addr == PAGE_REG_ADDR) ?
                     ext_ram_page_register : 8'h00;
  assign xmove_rdata = xmove_rdata_r;
  assign flash_write_req = flash_write_req_r;

  // page register: only the select bit is stored
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      page_select_bit_r <= PAGE_REG_RESET[PAGE_BIT_POS];
    end else if (page_wr) begin
      page_select_bit_r <= sfr_wdata[PAGE_BIT_POS];
    end
  end

  // ram array, no reset on contents
  always_ff @(posedge sys_clk) begin
    if (ram_wr) begin
      ram_r[ram_idx] <= xmove_wdata;
    end
  end

  // read data holds between reads; flash request lasts one cycle
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      xmove_rdata_r     <= 8'h00;
      flash_write_req_r <= 1'b0;
    end else begin
      if (xm_read) begin
        xmove_rdata_r <= ram_r[ram_idx];
      end
      flash_write_req_r <= flash_write_req_nxt;
    end
  end

  // checks
  logic [7:0]        chk_data;
  logic [RAM_AW-1:0] chk_idx;
  assign chk_data = ram_r[ram_idx];
  assign chk_idx  = ram_idx;

  property p_unused_zero;
    @(posedge sys_clk) disable iff (!resetn)
    sfr_addr == PAGE_REG_ADDR |-> sfr_rdata[7:1] == PAGE_REG_UNUSED;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("page register upper bits not zero");

  property p_reset_page;
    @(posedge sys_clk) !resetn |=> page_select_bit_r == 1'b0;
  endproperty
  a_reset_page: assert property (p_reset_page)
    else $error("page register not cleared by reset");

  property p_page_write;
    @(posedge sys_clk) disable iff (!resetn)
    page_wr |=> ext_ram_page_register == {7'h00, $past(sfr_wdata[0])};
  endproperty
  a_page_write: assert property (p_page_write)
    else $error("page select not loaded from write");

  property p_indirect_addr;
    @(posedge sys_clk) disable iff (!resetn)
    xmove_en && xmove_indirect |->
      ram_idx == {page_select_bit_r, xmove_reg_addr};
  endproperty
  a_indirect_addr: assert property (p_indirect_addr)
    else $error("indirect address wrong page");

  property p_mirror;
    @(posedge sys_clk) disable iff (!resetn)
    xmove_en && !xmove_indirect |-> ram_idx == data_pointer[8:0];
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("pointer address not mirrored");

  property p_read_data;
    @(posedge sys_clk) disable iff (!resetn)
    xmove_en && !xmove_wr |=> xmove_rdata == $past(chk_data);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read data differs from ram");

  property p_write_ram;
    @(posedge sys_clk) disable iff (!resetn)
    xmove_en && xmove_wr && !flash_write_enable |=>
      ram_r[$past(chk_idx)] == $past(xmove_wdata);
  endproperty
  a_write_ram: assert property (p_write_ram)
    else $error("ram write lost");

  property p_flash_divert;
    @(posedge sys_clk) disable iff (!resetn)
    xmove_en && xmove_wr && flash_write_enable |=>
      flash_write_req && ram_r[$past(chk_idx)] == $past(chk_data);
  endproperty
  a_flash_divert: assert property (p_flash_divert)
    else $error("flash write reached ram");

  property p_no_flash_req;
    @(posedge sys_clk) disable iff (!resetn)
    !(xmove_en && xmove_wr && flash_write_enable) |=> !flash_write_req;
  endproperty
  a_no_flash_req: assert property (p_no_flash_req)
    else $error("spurious flash write request");

  // holds, reads under flash enable, unmapped reads and write then read back
  property p_rdata_hold;
    @(posedge sys_clk) disable iff (!resetn)
    !xm_read |=> $stable(xmove_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");

  property p_page_hold;
    @(posedge sys_clk) disable iff (!resetn)
    !page_wr |=> $stable(page_select_bit_r);
  endproperty
  a_page_hold: assert property (p_page_hold)
    else $error("page select changed without a write");

  property p_flash_read;
    @(posedge sys_clk) disable iff (!resetn)
    xm_read && flash_write_enable |=>
      !flash_write_req && xmove_rdata == $past(chk_data);
  endproperty
  a_flash_read: assert property (p_flash_read)
    else $error("read under flash enable lost ram data");

  property p_sfr_other;
    @(posedge sys_clk) disable iff (!resetn)
    sfr_addr != PAGE_REG_ADDR |-> sfr_rdata == 8'h00;
  endproperty
  a_sfr_other: assert property (p_sfr_other)
    else $error("unmapped register read not zero");

  property p_write_read_back;
    @(posedge sys_clk) disable iff (!resetn)
    ram_wr ##1 (xm_read && ram_idx == $past(ram_idx)) |=>
      xmove_rdata == $past(xmove_wdata, 2);
  endproperty
  a_write_read_back: assert property (p_write_read_back)
    else $error("byte read back differs from byte written");

  c_indirect_wr: cover property (@(posedge sys_clk) disable iff (!resetn)
    xmove_en && xmove_wr && xmove_indirect && page_select_bit_r);
  c_pointer_rd: cover property (@(posedge sys_clk) disable iff (!resetn)
    xmove_en && !xmove_wr && !xmove_indirect && data_pointer[15:9] != 7'h00);
  c_flash_wr: cover property (@(posedge sys_clk) disable iff (!resetn)
    xmove_en && xmove_wr && flash_write_enable);
  // read under flash enable, in any page and address mode
  c_flash_rd: cover property (@(posedge sys_clk) disable iff (!resetn)
    xm_read && flash_write_enable);
  c_page_set: cover property (@(posedge sys_clk) disable iff (!resetn)
    page_wr && sfr_wdata[PAGE_BIT_POS]);

endmodule : paged_ext_data_ram
`default_nettype wire

// ### verif/core_model.sv
// core model: issues sfr writes and external moves to the ram
// assumes each call starts at a falling edge of sys_clk
`default_nettype none
module core_model (
  output var logic        sfr_wr,
  output var logic [7:0]  sfr_addr,
  output var logic [7:0]  sfr_wdata,
  output var logic        flash_write_enable,
  output var logic        xmove_en,
  output var logic        xmove_wr,
  output var logic        xmove_indirect,
  output var logic [15:0] data_pointer,
  output var logic [7:0]  xmove_reg_addr,
  output var logic [7:0]  xmove_wdata,
  input  wire logic       sys_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {sfr_wr, sfr_addr, sfr_wdata, flash_write_enable} = '0;
    {xmove_en, xmove_wr, xmove_indirect, data_pointer} = '0;
    {xmove_reg_addr, xmove_wdata} = '0;
  end
  task automatic sfr(input logic w, input logic [7:0] a, d);
    xmove_en = 1'b0;
    {sfr_wr, sfr_addr, sfr_wdata} = {w, a, d};
    @(negedge sys_clk);
  endtask : sfr
  // c is {flash enable, strobe, write, indirect}
  task automatic xm(input logic [3:0] c, input logic [15:0] p,
                    input logic [7:0] r, d);
    sfr_wr = 1'b0;
    {flash_write_enable, xmove_en, xmove_wr, xmove_indirect} = c;
    // idle address and data lines keep moving
    data_pointer = c[2] ? p : ~data_pointer;
    xmove_reg_addr = c[2] ? r : ~xmove_reg_addr;
    xmove_wdata = c[2] ? d : ~xmove_wdata;
    @(negedge sys_clk);
  endtask : xm
endmodule : core_model
`default_nettype wire

// ### verif/testbench.sv
// testbench: core model drives the paged ram, readback judged here
// assumes ext_ram_pkg, the ram and core_model are compiled first
`default_nettype none
module testbench
  import ext_ram_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  int bad_count = 0;
  int total_checks = 0;
  wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, xmove_reg_addr;
  wire logic [7:0] xmove_wdata, xmove_rdata;
  wire logic [15:0] data_pointer;
  wire logic sfr_wr, xmove_en, xmove_wr, xmove_indirect;
  wire logic flash_write_enable, flash_write_req;
  always #25 sys_clk = ~sys_clk;
  paged_ext_data_ram dut_u (.sys_clk, .resetn, .sfr_addr, .sfr_wr,
    .sfr_wdata, .sfr_rdata, .xmove_en, .xmove_wr, .xmove_indirect,
    .data_pointer, .xmove_reg_addr, .xmove_wdata, .xmove_rdata,
    .flash_write_enable, .flash_write_req);
  core_model core_u (.sys_clk, .sfr_addr, .sfr_wr, .sfr_wdata,
    .xmove_en, .xmove_wr, .xmove_indirect, .data_pointer,
    .xmove_reg_addr, .xmove_wdata, .flash_write_enable);
  task automatic chk(input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test;
    if (bad_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic t_page;
    core_u.sfr(1'b0, 8'haa, 8'h00);
    chk(sfr_rdata, 8'h00);
    chk(xmove_rdata | {7'h00, flash_write_req}, 8'h00);
    core_u.sfr(1'b1, 8'haa, 8'hff);
    chk(sfr_rdata, 8'h01);
    core_u.sfr(1'b1, 8'haa, 8'hfe);
    chk(sfr_rdata, 8'h00);
    core_u.sfr(1'b1, 8'hab, 8'h01);
    chk(sfr_rdata, 8'h00);
    core_u.sfr(1'b0, 8'haa, 8'h00);
    chk(sfr_rdata, 8'h00);
  endtask : t_page
  task automatic t_mirror;
    core_u.xm(4'h6, 16'h0000, 8'h00, 8'h5a);
    core_u.xm(4'h6, 16'hfdff, 8'h00, 8'ha5);
    core_u.xm(4'h4, 16'h0200, 8'h00, 8'h00);
    chk(xmove_rdata, 8'h5a);
    core_u.xm(4'h4, 16'h01ff, 8'h00, 8'h00);
    chk(xmove_rdata, 8'ha5);
    core_u.xm(4'h6, 16'h0a01, 8'h00, 8'h96);
    core_u.xm(4'h4, 16'h0201, 8'h00, 8'h00);
    chk(xmove_rdata, 8'h96);
  endtask : t_mirror
  task automatic t_indirect;
    core_u.sfr(1'b1, 8'haa, 8'h01);
    core_u.xm(4'h7, 16'h0000, 8'h10, 8'h3c);
    core_u.xm(4'h6, 16'h0010, 8'h00, 8'hc3);
    core_u.xm(4'h4, 16'h0110, 8'h00, 8'h00);
    chk(xmove_rdata, 8'h3c);
    core_u.sfr(1'b1, 8'haa, 8'h00);
    core_u.xm(4'h5, 16'hffff, 8'h10, 8'h00);
    chk(xmove_rdata, 8'hc3);
  endtask : t_indirect
  task automatic t_flash;
    core_u.xm(4'he, 16'h0000, 8'h00, 8'h77);
    chk({7'h00, flash_write_req}, 8'h01);
    core_u.xm(4'hc, 16'h03ff, 8'h00, 8'h00);
    chk({7'h00, flash_write_req}, 8'h00);
    chk(xmove_rdata, 8'ha5);
    core_u.xm(4'h4, 16'h0400, 8'h00, 8'h00);
    chk({7'h00, flash_write_req}, 8'h00);
    chk(xmove_rdata, 8'h5a);
  endtask : t_flash
  task automatic t_reset;
    core_u.sfr(1'b1, 8'haa, 8'h01);
    chk(sfr_rdata, 8'h01);
    resetn = 1'b0;
    core_u.sfr(1'b0, 8'haa, 8'h00);
    chk(sfr_rdata, 8'h00);
    chk(xmove_rdata | {7'h00, flash_write_req}, 8'h00);
    resetn = 1'b1;
    core_u.xm(4'h5, 16'h0000, 8'h10, 8'h00);
    chk(xmove_rdata, 8'hc3);
    core_u.xm(4'h4, 16'h0e00, 8'h00, 8'h00);
    chk(xmove_rdata, 8'h5a);
  endtask : t_reset
  // scenarios need well under 100 cycles; allow 2000
  initial begin
    #100000;
    bad_count++;
    end_of_test();
  end
  initial begin
    repeat (2) @(negedge sys_clk);
    resetn = 1'b1;
    t_page();
    t_mirror();
    t_indirect();
    t_flash();
    t_reset();
    core_u.xm(4'h0, 16'h0000, 8'h00, 8'h00);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
